// ==== rtl/hsm_supervisor.sv ====
// Documented master end: redundancy state, addressing and ping supervision
//
// Summary of operation
// - Standby address is configured minus one, 0 wraps 125
// - Old active goes passive only after peer active
// - Primary address via bus controller reinit only
// - Becoming active clears passive indication bit
// - No reparameterising slaves already in data exchange
// - Flag host when image data valid after switchover
// - Primary to offline leaves bus at once
// - Passive stop pings; offline or unconnected silent
// - Passive refuses clear and operate modes
// - Active stop answers pings, no slave traffic
// - Active clear answers pings, reads inputs only
// - Active operate answers pings, full data exchange
// - Passive pings repeatedly, active answers each
// - Ping failure clears communication ok bit
// - One ping request per token hold
// - Resend after slot wait, retry limit, then fail
// - Reclaim token after six plus twice address slots
// - Active polls each period, clears ok if none
// - Poll period max of 30 ms, rotation plus 10%
// - Keep passive station address low
// - Slave watchdog must cover switchover time
// - Passive only monitors, never self-activates
// - First ping request sets communication ok bit
`timescale 1ns/1ns
module hsm_supervisor #(
    parameter logic [15:0] SLOT_CYC   = 16'h0032,
    parameter logic [3:0]  MAX_RETRY  = hsm_pkg::RETRY_DEF,
    parameter int          ROT_MS     = 50
) (
    // Clock and reset
    input  wire logic                   clock,
    input  wire logic                   nrst,
    // Link
    hsm_link_if.master_a                link,
    // Host command
    input  wire hsm_pkg::hsm_cmd_type   hostCmd,
    input  wire hsm_pkg::hsm_opmode_type hostMode,
    input  wire logic [6:0]             cfgAddr,
    // Bus controller
    output logic                        ctrlReinit,
    output logic [6:0]                  stationAddress,
    output logic                        slaveTraffic,
    output logic                        outputsEnable,
    input  wire logic                   slaveInDataState,
    output logic                        reparamEnable,
    input  wire logic                   imageValid,
    // Status
    output hsm_pkg::hsm_rstate_type     rstate,
    output hsm_pkg::hsm_opmode_type     opMode,
    output logic                        passiveIndicationBit,
    output logic                        commOk,
    output logic                        dataValidFlag
);
    localparam int POLL_RAW = ROT_MS + (ROT_MS * hsm_pkg::MARGIN_PCT) / 100;
    localparam int POLL_MX = (POLL_RAW > hsm_pkg::POLL_MIN_MS) ?
        POLL_RAW : hsm_pkg::POLL_MIN_MS;
    // Rounded up to timer resolution
    localparam int POLL_MS = ((POLL_MX + hsm_pkg::POLL_RES_MS - 1) /
        hsm_pkg::POLL_RES_MS) * hsm_pkg::POLL_RES_MS;
    localparam int POLL_CYC = POLL_MS * hsm_pkg::CYC_PER_MS;
    if (SLOT_CYC == 16'h0000 || MAX_RETRY == 4'h0 ||
        ROT_MS < 1) begin : g_bad_params
        $error("hsm_supervisor: bad parameters");
    end

    typedef struct packed {
        hsm_pkg::hsm_rstate_type  rs;
        hsm_pkg::hsm_opmode_type  om;
        logic [6:0]               addr;
        logic                     reinit;
        logic                     ok;
        logic                     seen;
        logic                     req;
        logic                     res;
        logic                     waiting;
        logic                     tokPrev;
        logic [3:0]               retries;
        logic [15:0]              slotCnt;
        logic [23:0]              reclaimCnt;
        logic [31:0]              pollCnt;
        logic                     pendPassive;
        logic                     dv;
    } hsm_state_type;
    hsm_state_type s_q, s_d;

    function automatic logic [6:0] standby_addr(input logic [6:0] a);
        return (a == hsm_pkg::ADDR_ZERO) ? hsm_pkg::ADDR_WRAP :
            7'(a - 7'h01);
    endfunction : standby_addr

    logic [23:0] reclaimLimit;
    assign reclaimLimit = 24'(hsm_pkg::TTO_BASE_SLOTS) * 24'(SLOT_CYC) +
        24'(hsm_pkg::TTO_ADDR_MULT) * 24'(s_q.addr) * 24'(SLOT_CYC);

    always_comb begin
        s_d        = s_q;
        s_d.req    = 1'b0;
        s_d.res    = 1'b0;
        s_d.reinit = 1'b0;
        s_d.tokPrev = link.token;
        // State changes only on command; no self activation
        unique case (hostCmd)
            hsm_pkg::CMD_OFFLINE: begin
                s_d.rs = hsm_pkg::RS_OFFLINE;
                s_d.om = hsm_pkg::OM_OFFLINE;
                s_d.pendPassive = 1'b0;
            end
            hsm_pkg::CMD_STANDBY: begin
                if (s_q.rs == hsm_pkg::RS_ACTIVE && !link.bActive) begin
                    s_d.pendPassive = 1'b1;
                end else begin
                    s_d.rs = hsm_pkg::RS_PASSIVE;
                    s_d.om = hsm_pkg::OM_STOP;
                    s_d.addr = standby_addr(cfgAddr);
                end
            end
            hsm_pkg::CMD_PRIMARY: begin
                if (s_q.rs != hsm_pkg::RS_ACTIVE) begin
                    s_d.rs = hsm_pkg::RS_ACTIVE;
                    s_d.addr = cfgAddr;
                    s_d.reinit = 1'b1;
                    s_d.dv = 1'b0;
                    s_d.ok = 1'b0;
                    s_d.seen = 1'b0;
                    s_d.pollCnt = '0;
                end
                s_d.pendPassive = 1'b0;
            end
            hsm_pkg::CMD_NONE: begin
                if (s_q.pendPassive && link.bActive) begin
                    s_d.rs = hsm_pkg::RS_PASSIVE;
                    s_d.om = hsm_pkg::OM_STOP;
                    s_d.addr = standby_addr(cfgAddr);
                    s_d.pendPassive = 1'b0;
                end
            end
        endcase
        // Mode requests; passive is held in stop
        if (s_d.rs == hsm_pkg::RS_ACTIVE && hostMode != hsm_pkg::OM_OFFLINE)
            s_d.om = hostMode;
        else if (s_d.rs == hsm_pkg::RS_PASSIVE && s_d.om != hsm_pkg::OM_STOP)
            s_d.om = hsm_pkg::OM_STOP;
        if (s_q.rs == hsm_pkg::RS_ACTIVE && imageValid)
            s_d.dv = 1'b1;
        // Passive ping sequence
        if (s_q.rs == hsm_pkg::RS_PASSIVE && s_q.om == hsm_pkg::OM_STOP) begin
            if (link.token && !s_q.tokPrev && !s_q.waiting) begin
                s_d.req = 1'b1;
                s_d.waiting = 1'b1;
                s_d.slotCnt = '0;
                s_d.retries = '0;
            end else if (s_q.waiting) begin
                if (link.peerRes) begin
                    s_d.waiting = 1'b0;
                    s_d.ok = 1'b1;
                end else if (s_q.slotCnt == SLOT_CYC - 16'h0001) begin
                    s_d.slotCnt = '0;
                    if (s_q.retries == MAX_RETRY) begin
                        s_d.ok = 1'b0;
                        s_d.waiting = 1'b0;
                    end else begin
                        s_d.req = 1'b1;
                        s_d.retries = 4'(s_q.retries + 4'h1);
                    end
                end else begin
                    s_d.slotCnt = 16'(s_q.slotCnt + 16'h0001);
                end
            end
            // Token held by silent active: reclaim and ping
            if (!link.token && !s_q.waiting) begin
                if (s_q.reclaimCnt >= reclaimLimit) begin
                    s_d.reclaimCnt = '0;
                    s_d.req = 1'b1;
                    s_d.waiting = 1'b1;
                    s_d.slotCnt = '0;
                    s_d.retries = '0;
                end else begin
                    s_d.reclaimCnt = 24'(s_q.reclaimCnt + 24'h000001);
                end
            end else begin
                s_d.reclaimCnt = '0;
            end
        end else begin
            s_d.waiting = 1'b0;
            s_d.reclaimCnt = '0;
        end
        // Active side answers and polls
        if (s_q.rs == hsm_pkg::RS_ACTIVE && s_q.om != hsm_pkg::OM_OFFLINE) begin
            if (link.peerReq) begin
                s_d.res = 1'b1;
                s_d.seen = 1'b1;
                s_d.ok = 1'b1;
            end
            if (s_q.pollCnt == 32'(POLL_CYC - 1)) begin
                s_d.pollCnt = '0;
                if (!s_q.seen && !link.peerReq)
                    s_d.ok = 1'b0;
                s_d.seen = link.peerReq; // Set wins over clear
            end else begin
                s_d.pollCnt = 32'(s_q.pollCnt + 32'h1);
            end
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    logic act;
    assign act = s_q.rs == hsm_pkg::RS_ACTIVE;
    assign link.pingReq = s_q.req;
    assign link.pingRes = s_q.res;
    assign link.aActive = act;
    assign rstate = s_q.rs;
    assign opMode = s_q.om;
    assign stationAddress = s_q.addr;
    assign ctrlReinit = s_q.reinit;
    assign passiveIndicationBit = !act;
    assign commOk = s_q.ok;
    assign dataValidFlag = s_q.dv;
    assign slaveTraffic = act && (s_q.om == hsm_pkg::OM_CLEAR ||
        s_q.om == hsm_pkg::OM_OPERATE);
    assign outputsEnable = act && s_q.om == hsm_pkg::OM_OPERATE;
    assign reparamEnable = slaveTraffic && !slaveInDataState;
endmodule : hsm_supervisor

// ==== rtl/hsm_pkg.sv ====
// Shared constants and types for the redundant master pair supervisor
package hsm_pkg;
    // Redundancy states
    typedef enum logic [1:0] {
        RS_OFFLINE = 2'b00,
        RS_PASSIVE = 2'b01,
        RS_ACTIVE  = 2'b10
    } hsm_rstate_type;
    // Master operation modes
    typedef enum logic [1:0] {
        OM_OFFLINE = 2'b00,
        OM_STOP    = 2'b01,
        OM_CLEAR   = 2'b10,
        OM_OPERATE = 2'b11
    } hsm_opmode_type;
    // Host commands
    typedef enum logic [1:0] {
        CMD_NONE    = 2'b00,
        CMD_OFFLINE = 2'b01,
        CMD_STANDBY = 2'b10,
        CMD_PRIMARY = 2'b11
    } hsm_cmd_type;
    localparam int        CLK_HZ         = 20000000;
    localparam logic [6:0] ADDR_WRAP     = 7'h7D;
    localparam logic [6:0] ADDR_ZERO     = 7'h00;
    localparam int        TTO_BASE_SLOTS = 6;
    localparam int        TTO_ADDR_MULT  = 2;
    localparam int        POLL_MIN_MS    = 30;
    localparam int        POLL_RES_MS    = 5;
    localparam int        MARGIN_PCT     = 10;
    localparam int        CYC_PER_MS     = CLK_HZ / 1000;
    localparam logic [3:0] RETRY_DEF     = 4'h1;
endpackage : hsm_pkg

// ==== rtl/hsm_link_if.sv ====
// Fieldbus link between the two redundant masters
`timescale 1ns/1ns
interface hsm_link_if;
    logic pingReq;
    logic pingRes;
    logic token;
    logic aActive;
    logic bActive;
    logic peerReq;
    logic peerRes;
    // Requests and answers run both ways so either end can be active
    modport master_a (output pingReq, output pingRes, output aActive,
                      input token, input bActive, input peerReq,
                      input peerRes);
    modport master_b (output token, output bActive, output peerReq,
                      output peerRes, input pingReq, input pingRes,
                      input aActive);
endinterface : hsm_link_if

// ==== rtl/hsm_peer.sv ====
// Counterpart master end: token source, ping requester and responder
`timescale 1ns/1ns
module hsm_peer (
    // Clock and reset
    input  wire logic clock,
    input  wire logic nrst,
    // Link
    hsm_link_if.master_b link,
    // User side
    input  wire logic userActive,
    input  wire logic userToken,
    input  wire logic respondEnable,
    output logic      pingSeen
);
    typedef struct packed {
        logic tok;
        logic act;
        logic seen;
        logic req;
    } hsm_peer_type;
    hsm_peer_type s_q, s_d;
    always_comb begin
        s_d      = s_q;
        s_d.tok  = userToken;
        s_d.act  = userActive;
        // Answer only while active
        s_d.seen = link.pingReq & respondEnable & s_q.act;
        // One request each time the token comes back while passive
        s_d.req  = s_q.tok & ~userToken & ~s_q.act;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign link.token   = s_q.tok;
    assign link.bActive = s_q.act;
    assign link.peerReq = s_q.req;
    assign link.peerRes = s_q.seen;
    assign pingSeen     = s_q.seen;
endmodule : hsm_peer

// ==== testbench/hsm_supervisor_sva.sv ====
// Link protocol checker for the redundant master pair
`timescale 1ns/1ns
module hsm_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic nrst,
    // Link
    input wire logic pingReq,
    input wire logic pingRes,
    input wire logic token,
    input wire logic aActive,
    input wire logic bActive
);
    typedef struct packed {
        logic tokPrev;
        logic tokRise;
    } hsm_chk_state_type;
    hsm_chk_state_type state_q;
    hsm_chk_state_type state_d;
    // First ping of a token hold lands in the same cycle as this flag
    always_comb begin
        state_d         = state_q;
        state_d.tokPrev = token;
        state_d.tokRise = token && !state_q.tokPrev;
    end
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    req_pulse_a: assert property (pingReq |=> !pingReq)
        else $error("ping request longer than one cycle");
    res_pulse_a: assert property (pingRes |=> !pingRes)
        else $error("ping response longer than one cycle");
    req_passive_a: assert property (pingReq |-> !aActive)
        else $error("ping request while active");
    res_active_a: assert property (pingRes |-> aActive)
        else $error("ping response while not active");
    no_overlap_a: assert property (!(pingReq && pingRes))
        else $error("request and response together");
    req_spacing_a: assert property (pingReq |=> !pingReq [*3])
        else $error("resend before slot wait");
    hold_done_a: assert property (pingReq && bActive |=> !pingReq [*8])
        else $error("second ping in one token hold");
    retry_slot_a: assert property (
        pingReq && state_q.tokRise && !bActive |-> ##[7:9] pingReq)
        else $error("no resend after slot wait");
endmodule : hsm_checker

// ==== testbench/hot_standby_master_supervisor_tb.sv ====
// Self-checking bench for the redundant master pair supervisor
`timescale 1ns/1ns
module hot_standby_master_supervisor_tb;
    logic                    clock;
    logic                    nrst;
    hsm_pkg::hsm_cmd_type    hostCmd;
    hsm_pkg::hsm_opmode_type hostMode;
    logic [6:0]              cfgAddr;
    logic                    slaveInDataState;
    logic                    imageValid;
    logic                    userActive;
    logic                    userToken;
    logic                    ctrlReinit;
    logic [6:0]              stationAddress;
    logic                    slaveTraffic;
    logic                    outputsEnable;
    logic                    reparamEnable;
    hsm_pkg::hsm_rstate_type rstate;
    hsm_pkg::hsm_opmode_type opMode;
    logic                    passiveIndicationBit;
    logic                    commOk;
    logic                    dataValidFlag;
    logic                    peerSeen;
    int                      seens;
    int                      miscompares;
    int                      checks;
    int                      cycles;
    int                      pings;
    int                      p0;
    hsm_link_if hsm_link_if_i ();
    hsm_supervisor #(.SLOT_CYC(16'h0008)) hsm_supervisor_i (
        .clock(clock), .nrst(nrst), .link(hsm_link_if_i),
        .hostCmd(hostCmd), .hostMode(hostMode), .cfgAddr(cfgAddr),
        .ctrlReinit(ctrlReinit), .stationAddress(stationAddress),
        .slaveTraffic(slaveTraffic), .outputsEnable(outputsEnable),
        .slaveInDataState(slaveInDataState), .reparamEnable(reparamEnable),
        .imageValid(imageValid), .rstate(rstate), .opMode(opMode),
        .passiveIndicationBit(passiveIndicationBit), .commOk(commOk),
        .dataValidFlag(dataValidFlag));
    hsm_peer hsm_peer_i (
        .clock(clock), .nrst(nrst), .link(hsm_link_if_i),
        .userActive(userActive), .userToken(userToken),
        .respondEnable(1'b1), .pingSeen(peerSeen));
    hsm_checker hsm_checker_i (
        .clock(clock), .nrst(nrst), .pingReq(hsm_link_if_i.pingReq),
        .pingRes(hsm_link_if_i.pingRes), .token(hsm_link_if_i.token),
        .aActive(hsm_link_if_i.aActive), .bActive(hsm_link_if_i.bActive));
    initial begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end
    task automatic chk(input string nm, input logic [7:0] e, g);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic waitc(input int n);
        repeat (n) @(negedge clock);
    endtask : waitc
    task automatic cmd(input hsm_pkg::hsm_cmd_type c);
        @(negedge clock) hostCmd = c;
        @(negedge clock) hostCmd = hsm_pkg::CMD_NONE;
    endtask : cmd
    task automatic t_standby;
        cfgAddr = 7'h00;
        cmd(hsm_pkg::CMD_STANDBY);
        chk("addr", 8'h7D, stationAddress);
        cmd(hsm_pkg::CMD_OFFLINE);
        cfgAddr = 7'h02; // Low passive address keeps reclaim short
        cmd(hsm_pkg::CMD_STANDBY);
        chk("addr", 8'h01, stationAddress);
        hostMode = hsm_pkg::OM_CLEAR;
        waitc(3);
        chk("mode", hsm_pkg::OM_STOP, opMode);
        hostMode = hsm_pkg::OM_STOP;
    endtask : t_standby
    // Token hold stays long enough to rule out a ping beyond nPing
    task automatic t_ping(input logic peerUp, input logic [7:0] nPing);
        int s0;
        userActive = peerUp;
        p0 = pings;
        s0 = seens;
        userToken = 1'b1;
        waitc(4);
        chk("commOk", 8'h01, commOk);
        waitc(36);
        chk("commOk", {7'h00, peerUp}, commOk);
        chk("pings", nPing, 8'(pings - p0));
        chk("answers", 8'(peerUp), 8'(seens - s0));
        chk("state", hsm_pkg::RS_PASSIVE, rstate);
        userToken = 1'b0;
        waitc(12);
    endtask : t_ping
    // Slaves assumed to outlast the switchover
    task automatic t_primary;
        slaveInDataState = 1'b1;
        cmd(hsm_pkg::CMD_PRIMARY);
        chk("reinit", 8'h01, ctrlReinit);
        waitc(1);
        chk("addr", 8'h02, stationAddress);
        chk("passive", 8'h00, passiveIndicationBit);
        chk("reparam", 8'h00, reparamEnable);
        chk("commOk", 8'h00, commOk);
        // Passive peer pings once as its token comes back
        userToken = 1'b1;
        waitc(2);
        userToken = 1'b0;
        waitc(2);
        chk("response", 8'h01, hsm_link_if_i.pingRes);
        chk("commOk", 8'h01, commOk);
        chk("valid", 8'h00, dataValidFlag);
        imageValid = 1'b1;
        waitc(3);
        chk("valid", 8'h01, dataValidFlag);
        for (int i = 1; i < 4; i++) begin
            hostMode = hsm_pkg::hsm_opmode_type'(i);
            waitc(3);
            chk("mode", 8'(i), opMode);
            chk("traffic", 8'(i > 1), slaveTraffic);
            chk("outputs", 8'(i == 3), outputsEnable);
            chk("reparam", 8'h00, reparamEnable);
        end
        slaveInDataState = 1'b0;
        waitc(1);
        chk("reparam", 8'h01, reparamEnable);
    endtask : t_primary
    task automatic t_handover;
        userActive = 1'b0;
        cmd(hsm_pkg::CMD_STANDBY);
        waitc(4);
        chk("state", hsm_pkg::RS_ACTIVE, rstate);
        userActive = 1'b1;
        waitc(4);
        chk("state", hsm_pkg::RS_PASSIVE, rstate);
        cmd(hsm_pkg::CMD_PRIMARY);
        waitc(2);
        cmd(hsm_pkg::CMD_OFFLINE);
        chk("state", hsm_pkg::RS_OFFLINE, rstate);
        chk("traffic", 8'h00, slaveTraffic);
        p0 = pings;
        userToken = 1'b1;
        waitc(12);
        chk("pings", 8'h00, 8'(pings - p0));
    endtask : t_handover
    task automatic complete_run;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : complete_run
    always @(posedge clock) begin
        cycles++;
        if (hsm_link_if_i.pingReq === 1'b1) begin
            pings++;
        end
        if (peerSeen === 1'b1) begin
            seens++;
        end
        if (cycles == 5000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        {miscompares, checks, cycles, pings, seens} = '0;
        {nrst, slaveInDataState, imageValid, userActive, userToken} = '0;
        hostCmd = hsm_pkg::CMD_NONE;
        hostMode = hsm_pkg::OM_STOP;
        cfgAddr = 7'h02;
        waitc(20);
        nrst = 1'b1;
        waitc(1);
        chk("state", hsm_pkg::RS_OFFLINE, rstate);
        chk("commOk", 8'h00, commOk);
        chk("passive", 8'h01, passiveIndicationBit);
        t_standby();
        t_ping(1'b1, 8'h01);
        t_ping(1'b0, 8'h02);
        t_primary();
        t_handover();
        complete_run();
    end
endmodule : hot_standby_master_supervisor_tb
